/* File: hdl/cts_pkg.sv */
package cts_pkg;
  // ==================================================
  // Tag store geometry
  localparam int IDX_W     = 9;
  localparam int TAG_W     = 8;
  localparam int DEPTH     = 512;
  // ==================================================
  // Cycle timing (ns and derived cycles at 100 MHz)
  localparam int CLK_NS      = 10;
  localparam int RST_PULSE_NS = 35;
  localparam int ACCESS_NS   = 90;
  localparam int RST_CYC    = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] RST_CNT  = 4'(RST_CYC);
  localparam logic [3:0] ACC_CNT  = 4'(ACC_CYC);
  // Match pin is first sampled a cycle past the slowest access time,
  // then needs the synchroniser stages before the result is read
  localparam int SYNC_STAGES  = 2;
  localparam int CMP_CYC      = ACC_CYC + SYNC_STAGES;
  localparam logic [3:0] CMP_CNT  = 4'(CMP_CYC);
  // ==================================================
  // Operation codes on the user side
  typedef enum logic [1:0] {
    CTS_OP_CMP   = 2'h0,
    CTS_OP_WR    = 2'h1,
    CTS_OP_WRBAD = 2'h2,
    CTS_OP_CLR   = 2'h3
  } cts_op_t;
endpackage

/* File: hdl/cts_pin_if.sv */
`timescale 1ns/100ps
// ==================================================
// Synchronised status pins from the tag store
interface cts_pin_if;
  logic match_s;
  logic perr_n_s;
  modport drv (output match_s, output perr_n_s);
  modport use_ (input match_s, input perr_n_s);
endinterface

/* File: hdl/cts_sync.sv */
`timescale 1ns/100ps
// ==================================================
// Two-stage synchroniser for the tag store status pins
module cts_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Raw pins
  input  wire logic match_pin,
  input  wire logic perr_n_pin,
  // Synchronised copies
  cts_pin_if.drv    sp
);
  typedef struct packed {
    logic [1:0] m;
    logic [1:0] p;
  } cts_sync_t;
  cts_sync_t st_r, st_nxt;
  // First stage only feeds the second stage
  always_comb begin
    st_nxt   = st_r;
    st_nxt.m = {st_r.m[0], match_pin};
    st_nxt.p = {st_r.p[0], perr_n_pin};
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '{m: 2'h0, p: 2'h3};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign sp.match_s  = st_r.m[1];
  assign sp.perr_n_s = st_r.p[1];
endmodule

/* File: hdl/cts_ctrl.sv */
`timescale 1ns/100ps
module cts_ctrl
  import cts_pkg::*;
#(
  parameter int SLICES = 1
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // User request
  input  wire logic                           req_valid,
  input  wire cts_pkg::cts_op_t               req_op,
  input  wire logic [cts_pkg::IDX_W-1:0]      req_index,
  input  wire logic [SLICES*cts_pkg::TAG_W-1:0] req_tag,
  output logic                                req_ready,
  // User answer
  output logic                                rsp_valid,
  output logic                                rsp_hit,
  output logic                                rsp_perr,
  // Tag store pins
  output logic [cts_pkg::IDX_W-1:0]           index_addr,
  output logic [SLICES*cts_pkg::TAG_W-1:0]    tag_in,
  output logic                                cs_n,
  output logic                                we_n,
  output logic                                clr_n,
  input  wire logic [SLICES-1:0]              match_pin,
  input  wire logic [SLICES-1:0]              perr_n_in,
  output logic [SLICES-1:0]                   perr_n_out,
  output logic [SLICES-1:0]                   perr_n_oe
);
  import cts_pkg::*;

  // ==================================================
  // Pin synchronisers, one per slice
  logic [SLICES-1:0] m_s;
  logic [SLICES-1:0] p_s;
  for (genvar g = 0; g < SLICES; g++) begin : g_sl
    cts_pin_if sp ();
    cts_sync u_sync (
      .clk        (clk),
      .reset      (reset),
      .match_pin  (match_pin[g]),
      .perr_n_pin (perr_n_in[g]),
      .sp         (sp.drv)
    );
    assign m_s[g] = sp.match_s;
    assign p_s[g] = sp.perr_n_s;
  end

  // ==================================================
  // State
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_CMP  = 5'h02,
    S_WR   = 5'h04,
    S_CLR  = 5'h08,
    S_REC  = 5'h10
  } cts_st_t;
  typedef struct packed {
    cts_st_t                     st;
    logic [3:0]                  cnt;
    logic [IDX_W-1:0]            idx;
    logic [SLICES*TAG_W-1:0]     tag;
    logic                        cs_n;
    logic                        we_n;
    logic                        clr_n;
    logic                        pdrv;
    logic                        rdy;
    logic                        rv;
    logic                        hit;
    logic                        perr;
  } cts_ctrl_t;
  cts_ctrl_t s_r;
  cts_ctrl_t s_nxt;

  // ==================================================
  // Reset value: strobes and clear released, ready for a request
  localparam cts_ctrl_t S_RST = '{
    st:    S_IDLE,
    cnt:   CNT_ZERO,
    idx:   '0,
    tag:   '0,
    cs_n:  1'b1,
    we_n:  1'b1,
    clr_n: 1'b1,
    pdrv:  1'b0,
    rdy:   1'b1,
    rv:    1'b0,
    hit:   1'b0,
    perr:  1'b0
  };

  // ==================================================
  // Next state
  always_comb begin
    s_nxt     = s_r;
    s_nxt.rv  = 1'b0;
    if (s_r.cnt != CNT_ZERO) begin
      s_nxt.cnt = s_r.cnt - 4'h1;
    end
    case (s_r.st)
      S_IDLE: begin
        if (req_valid && s_r.rdy) begin
          s_nxt.rdy = 1'b0;
          s_nxt.idx = req_index;
          s_nxt.tag = req_tag;
          s_nxt.cnt = ACC_CNT;
          case (req_op)
            CTS_OP_CMP: begin
              // Wait out the slowest access time and the synchroniser
              s_nxt.cnt  = CMP_CNT;
              s_nxt.cs_n = 1'b0;
              s_nxt.we_n = 1'b1;
              s_nxt.st   = S_CMP;
            end
            CTS_OP_WR, CTS_OP_WRBAD: begin
              // Write control falls a cycle later, so index and tag are
              // settled before the store starts writing
              s_nxt.cs_n = 1'b0;
              s_nxt.we_n = 1'b1;
              s_nxt.pdrv = (req_op == CTS_OP_WRBAD);
              s_nxt.st   = S_WR;
            end
            default: begin
              s_nxt.clr_n = 1'b0;
              s_nxt.cnt   = RST_CNT;
              s_nxt.st    = S_CLR;
            end
          endcase
        end
      end
      S_CMP: begin
        // Wait covers access time plus synchroniser lag
        if (s_r.cnt == CNT_ZERO) begin
          s_nxt.rv   = 1'b1;
          s_nxt.hit  = &m_s;
          s_nxt.perr = ~&p_s;
          s_nxt.cs_n = 1'b1;
          s_nxt.st   = S_REC;
        end
      end
      S_WR: begin
        if (s_r.cnt == ACC_CNT) begin
          s_nxt.we_n = 1'b0;
        end
        if (s_r.cnt == CNT_ZERO) begin
          // Write control rises before chip select drops away
          s_nxt.we_n = 1'b1;
          s_nxt.rv   = 1'b1;
          s_nxt.hit  = 1'b0;
          s_nxt.perr = 1'b0;
          s_nxt.st   = S_REC;
        end
      end
      S_CLR: begin
        if (s_r.cnt == CNT_ZERO) begin
          s_nxt.clr_n = 1'b1;
          s_nxt.rv    = 1'b1;
          s_nxt.hit   = 1'b0;
          s_nxt.perr  = 1'b0;
          s_nxt.st    = S_REC;
        end
      end
      S_REC: begin
        // One idle cycle with write control already high; chip select and parity
        // drive release at its end, and the store is never written here
        s_nxt.cs_n = 1'b1;
        s_nxt.pdrv = 1'b0;
        s_nxt.rdy  = 1'b1;
        s_nxt.st   = S_IDLE;
      end
      default: begin
        s_nxt = s_r;
        s_nxt.st = S_IDLE;
      end
    endcase
  end

  // ==================================================
  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==================================================
  // User outputs straight from the state register
  assign req_ready  = s_r.rdy;
  assign rsp_valid  = s_r.rv;
  assign rsp_hit    = s_r.hit;
  assign rsp_perr   = s_r.perr;

  // ==================================================
  // Tag store pins, also registered
  assign index_addr = s_r.idx;
  assign tag_in     = s_r.tag;
  assign cs_n       = s_r.cs_n;
  assign we_n       = s_r.we_n;
  assign clr_n      = s_r.clr_n;

  // ==================================================
  // Open-drain error pin: only ever drives low
  assign perr_n_out = '0;
  assign perr_n_oe  = {SLICES{s_r.pdrv}};
endmodule

/* File: tb/cts_dev_model.sv */
`timescale 1ns/100ps
// ==================================================
// Behavioural tag store facing the controller
module cts_dev_model (
  // Store pins
  input  wire logic [8:0] index_addr,
  input  wire logic [7:0] tag_in,
  input  wire logic       cs_n,
  input  wire logic       we_n,
  input  wire logic       clr_n,
  input  wire logic       parity_err_n,
  // Status pins
  output logic            match,
  output logic            perr_pull
);
  logic [8:0] mem_r [512];
  logic [8:0] word;
  // Clear and write are both level driven, like static cells; one process
  // owns the array, and a clear pulse wins over any write
  always @* begin
    if (!clr_n) begin
      for (int i = 0; i < 512; i++) begin
        mem_r[i] = 9'h000;
      end
    end else if (!cs_n && !we_n) begin
      mem_r[index_addr] = {(^tag_in) ^ !parity_err_n, tag_in};
    end
  end
  assign word      = mem_r[index_addr];
  assign perr_pull = !cs_n && we_n && (^word);
  assign match     = (cs_n || !we_n || !clr_n) ? 1'b1 :
                     (!(^word) && word == {^tag_in, tag_in});
endmodule

/* File: tb/cts_ctrl_props.sv */
`timescale 1ns/100ps
// ==================================================
// Pin sequence checks on the controller
module cts_ctrl_props
  import cts_pkg::*;
#(
  parameter int SLICES = 1
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              req_valid,
  input wire cts_pkg::cts_op_t  req_op,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic              rsp_hit,
  input wire logic              rsp_perr,
  input wire logic              cs_n,
  input wire logic              we_n,
  input wire logic              clr_n,
  input wire logic [SLICES-1:0] perr_n_out,
  input wire logic [SLICES-1:0] perr_n_oe
);
  logic take;
  assign take = req_valid && req_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_cmp_strobes: assert property (take && req_op == CTS_OP_CMP |-> ##2 (!cs_n && we_n) [*7])
    else $error("compare strobes wrong");
  a_wr_setup: assert property (take && (req_op == CTS_OP_WR || req_op == CTS_OP_WRBAD)
    |-> ##1 (!cs_n && we_n) ##1 (!cs_n && !we_n))
    else $error("write control before index settled");
  a_wr_strobes: assert property (take && (req_op == CTS_OP_WR || req_op == CTS_OP_WRBAD)
    |-> ##2 (!cs_n && !we_n) [*7])
    else $error("write strobes wrong");
  a_forced_pull: assert property (take && req_op == CTS_OP_WRBAD |-> ##2 perr_n_oe[0] [*7])
    else $error("forced error not pulled");
  a_pull_in_write: assert property (perr_n_oe != '0 |-> !cs_n && perr_n_out == '0)
    else $error("error pin pulled outside write");
  a_clear_pulse: assert property (take && req_op == CTS_OP_CLR |-> ##1 !clr_n [*5] ##1 clr_n)
    else $error("clear pulse wrong");
  a_idle_release: assert property (req_ready |-> cs_n && clr_n)
    else $error("pins active while idle");
  a_perr_no_hit: assert property (rsp_valid && rsp_perr |-> !rsp_hit)
    else $error("hit with parity error");
  a_rsp_time: assert property (take && (req_op == CTS_OP_WR || req_op == CTS_OP_WRBAD)
    |-> ##11 rsp_valid)
    else $error("write answer mistimed");
  a_cmp_time: assert property (take && req_op == CTS_OP_CMP |-> ##13 rsp_valid)
    else $error("compare answer mistimed");
endmodule
bind cts_ctrl cts_ctrl_props #(.SLICES(SLICES)) cts_ctrl_props_i (.clk(clk), .reset(reset),
  .req_valid(req_valid), .req_op(req_op), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_hit(rsp_hit), .rsp_perr(rsp_perr), .cs_n(cs_n), .we_n(we_n), .clr_n(clr_n),
  .perr_n_out(perr_n_out), .perr_n_oe(perr_n_oe));

/* File: tb/cache_tag_store_comparator_tb_top.sv */
`timescale 1ns/100ps
module cache_tag_store_comparator_tb_top;
  import cts_pkg::*;
  logic       clk = 1'b0, reset = 1'b1, req_valid = 1'b0;
  cts_op_t    req_op = CTS_OP_CMP;
  logic [8:0] req_index = 9'h000, index_addr;
  logic [7:0] req_tag = 8'h00, tag_in;
  logic       req_ready, rsp_valid, rsp_hit, rsp_perr, cs_n, we_n, clr_n;
  logic       match, perr_pull, parity_err_n, perr_n_out, perr_n_oe;
  int         failures = 0, check_count = 0;
  always #5 clk = ~clk;
  // Open-drain error line with pull-up
  assign parity_err_n = !(perr_n_oe && !perr_n_out) && !perr_pull;
  cts_ctrl cts_ctrl_i (.clk(clk), .reset(reset), .req_valid(req_valid), .req_op(req_op),
    .req_index(req_index), .req_tag(req_tag), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_hit(rsp_hit), .rsp_perr(rsp_perr), .index_addr(index_addr), .tag_in(tag_in),
    .cs_n(cs_n), .we_n(we_n), .clr_n(clr_n), .match_pin(match), .perr_n_in(parity_err_n),
    .perr_n_out(perr_n_out), .perr_n_oe(perr_n_oe));
  cts_dev_model cts_dev_model_i (.index_addr(index_addr), .tag_in(tag_in), .cs_n(cs_n),
    .we_n(we_n), .clr_n(clr_n), .parity_err_n(parity_err_n), .match(match),
    .perr_pull(perr_pull));
  task finish_test;
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [1:0] exp);
    check_count++;
    if ({rsp_hit, rsp_perr} !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, {rsp_hit, rsp_perr}, exp);
    end
  endtask
  task do_op(input cts_op_t op, input logic [8:0] idx, input logic [7:0] tag);
    int n;
    @(negedge clk);
    req_valid = 1'b1; req_op = op; req_index = idx; req_tag = tag;
    for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(negedge clk);
    if (n == 50) begin
      failures++;
      finish_test();
    end
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 50; n++) @(negedge clk);
    if (n == 50) begin
      failures++;
      finish_test();
    end
  endtask
  // Back-to-back writes at both index ends, then compares
  task t_write_cmp;
    do_op(CTS_OP_WR, 9'h1ff, 8'ha5);
    do_op(CTS_OP_WR, 9'h000, 8'h3c);
    do_op(CTS_OP_CMP, 9'h1ff, 8'ha5); check(2'h2);
    do_op(CTS_OP_CMP, 9'h1ff, 8'ha4); check(2'h0);
    do_op(CTS_OP_CMP, 9'h000, 8'h3c); check(2'h2);
  endtask
  // Forced error, then a clean rewrite of the same word
  task t_forced_err;
    do_op(CTS_OP_WRBAD, 9'h007, 8'h81);
    do_op(CTS_OP_CMP, 9'h007, 8'h81); check(2'h1);
    do_op(CTS_OP_WR, 9'h007, 8'h81);
    do_op(CTS_OP_CMP, 9'h007, 8'h81); check(2'h2);
  endtask
  task t_clear;
    do_op(CTS_OP_CLR, 9'h000, 8'h00);
    do_op(CTS_OP_CMP, 9'h1ff, 8'ha5); check(2'h0);
    do_op(CTS_OP_CMP, 9'h005, 8'h00); check(2'h2);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_clear();
    t_write_cmp();
    t_forced_err();
    t_clear();
    finish_test();
  end
endmodule
